//--- core/tmr16_pkg.sv
// Package: constants, register map and types of the 16-bit timer block
// Behaviour
// R1: Gate value falling edge sets gate flag
// R2: Gate flag with enable raises interrupt request
// R3: Gate flag sets even with gating disabled
// R4: Count wraps FFFFh to 0000h, sets overflow
// R5: Rollover irq needs on, enable, peripheral, global
// R6: Software clears overflow flag, never hardware
// R7: Clear count and flag before enabling irqs
// R8: Counts asleep only in asynchronous external mode
// R9: Wake setup is software's configuration job
// R10: Overflow during sleep wakes the device
// R11: Timer oscillator keeps running during sleep
// R12: Capture copies count into capture pair
// R13: Compare match on equal pairs triggers event
// R14: Third clock pin RB4 if select one
// R15: Select register bits 7..2 read zero
// R16: Special trigger clears count, no overflow
// R17: Count write beats special trigger clear
// R18: Gate falling edge is one synchronous pulse
// R19: Overflow beats same-cycle flag clear
package tmr16_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   // Register offsets
   localparam logic [3:0]  OFF_CONTROL     = 4'h0;
   localparam logic [3:0]  OFF_COUNT_LOW   = 4'h1;
   localparam logic [3:0]  OFF_COUNT_HIGH  = 4'h2;
   localparam logic [3:0]  OFF_CAP_LOW     = 4'h3;
   localparam logic [3:0]  OFF_CAP_HIGH    = 4'h4;
   localparam logic [3:0]  OFF_CCP_MODE    = 4'h5;
   localparam logic [3:0]  OFF_IRQ_CTRL    = 4'h6;
   localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h7;
   localparam logic [3:0]  OFF_IRQ_ENABLE  = 4'h8;
   localparam logic [3:0]  OFF_IRQ_CLEAR   = 4'h9;
   localparam logic [3:0]  OFF_ALT_PIN     = 4'ha;
   // Control fields
   localparam int          CTL_ON_BIT      = 0;
   localparam int          CTL_SYNCDIS_BIT = 1;
   localparam int          CTL_EXTCLK_BIT  = 2;
   localparam int          CTL_SOSC_BIT    = 3;
   localparam int          CTL_GATE_BIT    = 4;
   // Irq control fields
   localparam int          IRQ_PERIPHERAL_IRQ_ENABLE_BIT    = 0;
   localparam int          IRQ_GIE_BIT     = 1;
   // Status layout
   localparam int          ST_OVF_BIT      = 0;
   localparam int          ST_GATE_BIT     = 1;
   localparam int          ST_CCP_BIT      = 2;
   localparam int          ALT_T3SEL_BIT   = 1;
   localparam logic [7:0]  ALT_MASK        = 8'h03;
   localparam logic [15:0] COUNT_MAX       = 16'hffff;
   localparam logic [15:0] COUNT_ZERO      = 16'h0000;
   localparam logic [15:0] COUNT_ONE       = 16'h0001;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
   localparam logic [2:0]  RESET_STATUS    = 3'h0;

   // Capture/compare modes
   typedef enum logic [1:0]
   {
      TMR16_CCP_OFF     = 2'b00,
      TMR16_CCP_CAPTURE = 2'b01,
      TMR16_CCP_COMPARE = 2'b10,
      TMR16_CCP_SPECIAL = 2'b11
   } tmr16_ccp_type;

   // Register bus request
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmr16_bus_type;
endpackage : tmr16_pkg

//--- core/tmr16_timer.sv
// Top: 16-bit timer with gate event, rollover irq, sleep wake, capture/compare
`timescale 1ns/10ps
module tmr16_timer
   import tmr16_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   // Register bus
   input  wire tmr16_bus_type bus_in,
   output logic [7:0]         rdata_out,
   // Pins and system
   input  wire logic          pin_rb4_in,
   input  wire logic          pin_rb5_in,
   input  wire logic          gate_value_in,
   input  wire logic          capture_event_in,
   input  wire logic          sleep_in,
   // Results
   output logic               irq_out,
   output logic               wake_out,
   output logic               special_trigger_out,
   output logic               osc_run_out
);
   ////////////////////////////////////////////////////////////////////////
   // Software visible registers
   logic [7:0]    timer_control_r;                // On, sync, source, osc, gate
   logic [15:0]   count_r;                        // Count pair, high byte on top
   logic [15:0]   count_nxt;
   logic [15:0]   capcomp_r;                      // Capture value or compare period
   tmr16_ccp_type ccp_mode_r;
   logic [1:0]    interrupt_control_r;            // Peripheral and global enables
   logic [2:0]    status_r;                       // Sticky event flags
   logic [2:0]    status_nxt;
   logic [2:0]    irq_en_r;
   logic [7:0]    alt_pin_function_select_r;

   // Pin synchronisers and edge memories
   // Three stages: two to settle, the third as edge memory for the gate
   logic [2:0]    rb4_sync_r;
   logic [2:0]    rb5_sync_r;
   logic [2:0]    gate_sync_r;
   logic          cap_sync0_r;
   logic          cap_sync1_r;
   logic          cap_prev_r;                     // Last settled capture level
   logic          ext_prev_r;                     // Last settled clock pin level

   ////////////////////////////////////////////////////////////////////////
   // Configuration checks
   // A field that no longer fits its register would read a wrong bit
   // without notice, so elaboration stops instead
   if (CTL_ON_BIT >= DATA_W || CTL_SYNCDIS_BIT >= DATA_W
       || CTL_EXTCLK_BIT >= DATA_W || CTL_SOSC_BIT >= DATA_W
       || CTL_GATE_BIT >= DATA_W || ALT_T3SEL_BIT >= DATA_W)
   begin : g_bad_field
      $error("register field outside the data width");
   end
   if (ST_OVF_BIT >= $bits(status_r) || ST_GATE_BIT >= $bits(status_r)
       || ST_CCP_BIT >= $bits(status_r))
   begin : g_bad_status
      $error("status flag outside the status register");
   end
   if (IRQ_PERIPHERAL_IRQ_ENABLE_BIT >= $bits(interrupt_control_r)
       || IRQ_GIE_BIT >= $bits(interrupt_control_r))
   begin : g_bad_irq_ctrl
      $error("interrupt enable outside its register");
   end
   if ($bits(rdata_out) != DATA_W || $bits(bus_in.addr) != ADDR_W)
   begin : g_bad_bus
      $error("bus widths differ from the package");
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode
   // One write strobe per register except the read-only status; reads decode in the mux below
   wire wr_ctl  = bus_in.wr && bus_in.addr == OFF_CONTROL;
   wire wr_lo   = bus_in.wr && bus_in.addr == OFF_COUNT_LOW;
   wire wr_hi   = bus_in.wr && bus_in.addr == OFF_COUNT_HIGH;
   wire wr_cl   = bus_in.wr && bus_in.addr == OFF_CAP_LOW;
   wire wr_ch   = bus_in.wr && bus_in.addr == OFF_CAP_HIGH;
   wire wr_mode = bus_in.wr && bus_in.addr == OFF_CCP_MODE;
   wire wr_ictl = bus_in.wr && bus_in.addr == OFF_IRQ_CTRL;
   wire wr_ien  = bus_in.wr && bus_in.addr == OFF_IRQ_ENABLE;
   wire wr_iclr = bus_in.wr && bus_in.addr == OFF_IRQ_CLEAR;
   wire wr_alt  = bus_in.wr && bus_in.addr == OFF_ALT_PIN;

   // Mode bits used all over the datapath
   wire timer_on = timer_control_r[CTL_ON_BIT];
   wire ext_mode = timer_control_r[CTL_EXTCLK_BIT];
   wire async_md = ext_mode && timer_control_r[CTL_SYNCDIS_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Clock pin steering and tick
   // Only synchronised stage [1] is looked at after the first flop; stage [2] is unused
   wire ext_clk_sel = alt_pin_function_select_r[ALT_T3SEL_BIT]
                      ? rb4_sync_r[1] : rb5_sync_r[1];          // R14
   wire ext_rise    = ext_clk_sel && !ext_prev_r;
   // Asleep only the asynchronous external mode keeps counting
   wire may_count   = timer_on && (!sleep_in || async_md);      // R8
   wire tick        = may_count && (ext_mode ? ext_rise : 1'b1);
   wire wrap        = tick && count_r == COUNT_MAX;              // R4

   ////////////////////////////////////////////////////////////////////////
   // Gate falling edge, one pulse per edge, regardless of gate enable
   wire gate_fall   = gate_sync_r[2] && !gate_sync_r[1];        // R18 R3

   ////////////////////////////////////////////////////////////////////////
   // Capture/compare
   wire cap_rise    = cap_sync1_r && !cap_prev_r;
   wire do_capture  = ccp_mode_r == TMR16_CCP_CAPTURE && cap_rise; // R12
   wire cmp_match   = (ccp_mode_r == TMR16_CCP_COMPARE
                       || ccp_mode_r == TMR16_CCP_SPECIAL)
                      && capcomp_r == count_r;                   // R13
   wire spec_trig   = ccp_mode_r == TMR16_CCP_SPECIAL && cmp_match;

   // Count next: write wins over special clear, clear gives no overflow
   always_comb
   begin
      count_nxt = count_r;
      if (spec_trig)
         count_nxt = COUNT_ZERO;                                 // R16
      else if (tick)
         count_nxt = count_r + COUNT_ONE;                        // R4
      if (wr_lo)
         count_nxt[7:0] = bus_in.wdata;                          // R17
      if (wr_hi)
         count_nxt[15:8] = bus_in.wdata;                         // R17
   end

   // Event sources of the sticky flags
   // Overflow is dropped when the same edge is a special trigger clear
   wire       ovf_set  = wrap && !spec_trig;                     // R16
   wire       gate_set = gate_fall;                              // R1
   wire       ccp_set  = cmp_match || do_capture;
   // Write-one-to-clear mask, empty unless the clear register is written
   wire [2:0] clr_mask = wr_iclr ? bus_in.wdata[2:0] : RESET_STATUS;

   // Status: clear first, then set, so a set in the same cycle wins
   always_comb
   begin
      status_nxt = status_r & ~clr_mask;                         // R6
      if (ovf_set)
         status_nxt[ST_OVF_BIT] = 1'b1;                          // R19
      if (gate_set)
         status_nxt[ST_GATE_BIT] = 1'b1;                         // R1
      if (ccp_set)
         status_nxt[ST_CCP_BIT] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt and wake requests
   // Overflow path needs peripheral enable; global enable gates the vector
   wire peripheral_irq_enable      = interrupt_control_r[IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
   wire global_irq_enable       = interrupt_control_r[IRQ_GIE_BIT];
   wire [2:0] pend = status_nxt & irq_en_r;
   wire ovf_req   = timer_on && pend[ST_OVF_BIT] && peripheral_irq_enable;        // R5
   wire gate_req  = pend[ST_GATE_BIT] && peripheral_irq_enable;                   // R2
   wire ccp_req   = pend[ST_CCP_BIT] && peripheral_irq_enable;
   wire irq_nxt   = global_irq_enable && (ovf_req || gate_req || ccp_req);     // R5 R2
   // Wake needs no global enable: the core resumes with or without vector
   wire wake_nxt  = sleep_in && (ovf_req || gate_req || ccp_req); // R10
   // Dedicated oscillator runs whenever enabled, sleep or not
   wire osc_nxt   = timer_control_r[CTL_SOSC_BIT];               // R11

   ////////////////////////////////////////////////////////////////////////
   // Read port
   // Read mux, unmapped reads zero
   logic [7:0] rd_mux;
   always_comb
   begin
      case (bus_in.addr)
         OFF_CONTROL:    rd_mux = timer_control_r;
         OFF_COUNT_LOW:  rd_mux = count_r[7:0];
         OFF_COUNT_HIGH: rd_mux = count_r[15:8];
         OFF_CAP_LOW:    rd_mux = capcomp_r[7:0];
         OFF_CAP_HIGH:   rd_mux = capcomp_r[15:8];
         OFF_CCP_MODE:   rd_mux = {6'h00, ccp_mode_r};
         OFF_IRQ_CTRL:   rd_mux = {6'h00, interrupt_control_r};
         OFF_IRQ_STATUS: rd_mux = {5'h00, status_r};
         OFF_IRQ_ENABLE: rd_mux = {5'h00, irq_en_r};
         OFF_ALT_PIN:    rd_mux = alt_pin_function_select_r & ALT_MASK; // R15
         default:        rd_mux = RESET_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for pin inputs
   // Clock pins: both stay synchronised, so a select change needs no resync
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rb4_sync_r <= 3'h0;
         rb5_sync_r <= 3'h0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         rb4_sync_r <= {rb4_sync_r[1:0], pin_rb4_in};
         rb5_sync_r <= {rb5_sync_r[1:0], pin_rb5_in};
         ext_prev_r <= ext_clk_sel;
      end
   end

   // Gate and capture pins; reset to the idle low level, so no false edge
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         gate_sync_r <= 3'h0;
         cap_sync0_r <= 1'b0;
         cap_sync1_r <= 1'b0;
         cap_prev_r  <= 1'b0;
      end
      else
      begin
         gate_sync_r <= {gate_sync_r[1:0], gate_value_in};
         cap_sync0_r <= capture_event_in;
         cap_sync1_r <= cap_sync0_r;
         cap_prev_r  <= cap_sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         timer_control_r           <= RESET_BYTE;
         interrupt_control_r       <= 2'h0;
         irq_en_r                  <= RESET_STATUS;
         ccp_mode_r                <= TMR16_CCP_OFF;
         alt_pin_function_select_r <= RESET_BYTE;
      end
      else
      begin
         if (wr_ctl)
            timer_control_r <= bus_in.wdata;
         if (wr_ictl)
            interrupt_control_r <= bus_in.wdata[1:0];
         if (wr_ien)
            irq_en_r <= bus_in.wdata[2:0];
         if (wr_mode)
            ccp_mode_r <= tmr16_ccp_type'(bus_in.wdata[1:0]);
         if (wr_alt)
            alt_pin_function_select_r <= bus_in.wdata & ALT_MASK; // R15 R14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Count pair and status flags
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count_r  <= COUNT_ZERO;
         status_r <= RESET_STATUS;
      end
      else
      begin
         count_r  <= count_nxt;
         status_r <= status_nxt;
      end
   end

   // Capture pair: a capture beats a software byte write in the same cycle
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         capcomp_r <= COUNT_ZERO;
      else if (do_capture)
         capcomp_r <= count_r;                                   // R12
      else if (wr_cl)
         capcomp_r[7:0] <= bus_in.wdata;
      else if (wr_ch)
         capcomp_r[15:8] <= bus_in.wdata;
   end

   // Read data stands for one cycle only, zero otherwise
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rdata_out <= RESET_BYTE;
      else
         rdata_out <= bus_in.rd ? rd_mux : RESET_BYTE;
   end

   // Registered results, so decode glitches never reach the pins
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         irq_out             <= 1'b0;
         wake_out            <= 1'b0;
         special_trigger_out <= 1'b0;
         osc_run_out         <= 1'b0;
      end
      else
      begin
         irq_out             <= irq_nxt;
         wake_out            <= wake_nxt;
         special_trigger_out <= spec_trig;                      // R13
         osc_run_out         <= osc_nxt;
      end
   end
endmodule : tmr16_timer

//--- sim/tmr16_timer_sva.sv
// Checker: port-level properties of the 16-bit timer
`timescale 1ns/10ps
module tmr16_timer_chk
   import tmr16_pkg::*;
(
   // Clock, reset and inputs
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire tmr16_bus_type bus_in,
   input  wire logic          sleep_in,
   // Outputs watched
   input  wire logic [7:0]    rdata_out,
   input  wire logic          irq_out,
   input  wire logic          wake_out,
   input  wire logic          special_trigger_out,
   input  wire logic          osc_run_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   // Read port: data only in the cycle after a read
   a_rdata_idle: assert property (!bus_in.rd |=> rdata_out == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (
      bus_in.rd && bus_in.addr > OFF_ALT_PIN |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_alt_rsvd_zero: assert property (
      bus_in.rd && bus_in.addr == OFF_ALT_PIN |=> rdata_out[7:2] == 6'h00)
      else $error("unused pin select bits not zero");
   a_clear_reads_zero: assert property (
      bus_in.rd && bus_in.addr == OFF_IRQ_CLEAR |=> rdata_out == 8'h00)
      else $error("clear register read not zero");
   ////////////////////////////////////////////////////////////////////////////////
   // Oscillator, interrupt and wake levels
   a_osc_follow: assert property (
      bus_in.wr && bus_in.addr == OFF_CONTROL
      |-> ##2 osc_run_out == $past(bus_in.wdata[CTL_SOSC_BIT], 2))
      else $error("oscillator run does not follow control");
   a_irq_needs_gie: assert property (
      bus_in.wr && bus_in.addr == OFF_IRQ_CTRL && !bus_in.wdata[IRQ_GIE_BIT] |-> ##2 !irq_out)
      else $error("interrupt without global enable");
   a_wake_needs_peripheral_irq_enable: assert property (
      bus_in.wr && bus_in.addr == OFF_IRQ_CTRL && !bus_in.wdata[IRQ_PERIPHERAL_IRQ_ENABLE_BIT] |-> ##2 !wake_out)
      else $error("wake without peripheral enable");
   a_wake_sleep_only: assert property (!sleep_in |=> !wake_out)
      else $error("wake while awake");
   // Main scenarios reached
   c_special: cover property (special_trigger_out);
   c_wake: cover property (wake_out);
   c_irq: cover property (irq_out);
endmodule : tmr16_timer_chk

bind tmr16_timer tmr16_timer_chk chk (.clk_sys_in, .rst_n_in, .bus_in, .sleep_in, .rdata_out,
   .irq_out, .wake_out, .special_trigger_out, .osc_run_out);

//--- sim/tmr16_far_end.sv
// Far side model: drives gate, capture and external clock pins
`timescale 1ns/10ps
module tmr16_far_end
(
   // Clock
   input  wire logic       clk_sys_in,
   // Pins: 0 gate, 1 capture, 2 RB4, 3 RB5
   output logic [3:0]      pins_out
);
   initial pins_out = 4'h0;
   // Slow pulses so the two-flop synchroniser sees each edge; idle low
   task automatic pulse(input int idx, input int n);
      repeat (n)
      begin
         @(posedge clk_sys_in);
         pins_out[idx] <= 1'b1;
         repeat (6) @(posedge clk_sys_in);
         pins_out[idx] <= 1'b0;
         repeat (6) @(posedge clk_sys_in);
      end
   endtask : pulse
endmodule : tmr16_far_end

//--- sim/tmr16_timer_tb.sv
// Testbench: register-level scenarios for the 16-bit timer
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tmr16_timer_tb
   import tmr16_pkg::*;
;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          sleep = 1'b0;
   tmr16_bus_type bus = '0;
   logic [3:0]    pins;
   logic [7:0]    rdata_out;
   logic          irq_out, wake_out, trig_out, osc_out;
   int            n_mismatch = 0, checks = 0, cyc = 0;
   always #5 clk = ~clk;
   tmr16_far_end far (.clk_sys_in(clk), .pins_out(pins));
   tmr16_timer uut (.clk_sys_in(clk), .rst_n_in(rst_n), .bus_in(bus), .rdata_out(rdata_out),
      .pin_rb4_in(pins[2]), .pin_rb5_in(pins[3]), .gate_value_in(pins[0]),
      .capture_event_in(pins[1]), .sleep_in(sleep), .irq_out(irq_out), .wake_out(wake_out),
      .special_trigger_out(trig_out), .osc_run_out(osc_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask : wr
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1;
      `CHK(rdata_out, exp)
   endtask : rd
   // Bounded wait for the compare trigger
   task automatic wait_trig(input int lim);
      int n;
      n = 0;
      while (trig_out !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(trig_out, 1'b1)
      repeat (4) @(posedge clk);
   endtask : wait_trig
   task automatic print_verdict();
      $display("mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFF_ALT_PIN, 8'h00);
      wr(OFF_ALT_PIN, 8'hff);
      rd(OFF_ALT_PIN, 8'h03);
      rd(4'hb, 8'h00);
      rd(OFF_IRQ_CLEAR, 8'h00);
      // Rollover near the top, count and flag prepared first
      wr(OFF_COUNT_HIGH, 8'hff);
      wr(OFF_COUNT_LOW, 8'hfe);
      wr(OFF_IRQ_CLEAR, 8'h07);
      wr(OFF_IRQ_ENABLE, 8'h01);
      wr(OFF_IRQ_CTRL, 8'h03);
      wr(OFF_CONTROL, 8'h01);
      // This clear lands on the wrap edge, the set must win
      wr(OFF_IRQ_CLEAR, 8'h01);
      repeat (8) @(posedge clk);
      rd(OFF_COUNT_HIGH, 8'h00);
      rd(OFF_IRQ_STATUS, 8'h01);
      `CHK(irq_out, 1'b1)
      wr(OFF_CONTROL, 8'h00);
      repeat (3) @(posedge clk);
      `CHK(irq_out, 1'b0)
      rd(OFF_IRQ_STATUS, 8'h01);
      wr(OFF_IRQ_CLEAR, 8'h01);
      rd(OFF_IRQ_STATUS, 8'h00);
      // Gate falling edge with gating disabled
      wr(OFF_IRQ_ENABLE, 8'h02);
      far.pulse(0, 1);
      rd(OFF_IRQ_STATUS, 8'h02);
      `CHK(irq_out, 1'b1)
      wr(OFF_IRQ_CLEAR, 8'h02);
      repeat (8) @(posedge clk);
      rd(OFF_IRQ_STATUS, 8'h00);
      // Capture of a stopped count
      wr(OFF_COUNT_LOW, 8'h34);
      wr(OFF_COUNT_HIGH, 8'h12);
      wr(OFF_CCP_MODE, 8'h01);
      far.pulse(1, 1);
      rd(OFF_CAP_LOW, 8'h34);
      rd(OFF_CAP_HIGH, 8'h12);
      // Special trigger acts as a period of 0x10
      wr(OFF_CAP_HIGH, 8'h00);
      wr(OFF_CAP_LOW, 8'h10);
      wr(OFF_COUNT_HIGH, 8'h00);
      wr(OFF_COUNT_LOW, 8'h00);
      wr(OFF_IRQ_CLEAR, 8'h07);
      wr(OFF_CCP_MODE, 8'h03);
      wr(OFF_CONTROL, 8'h01);
      wait_trig(40);
      wait_trig(30);
      // Trigger on the wrap edge itself must not raise the overflow flag
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_CAP_HIGH, 8'hff);
      wr(OFF_CAP_LOW, 8'hff);
      wr(OFF_COUNT_HIGH, 8'hff);
      wr(OFF_COUNT_LOW, 8'hf8);
      wr(OFF_CONTROL, 8'h01);
      wait_trig(20);
      // Stopped count equal to a zero period clears every cycle; write wins
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_CAP_HIGH, 8'h00);
      wr(OFF_CAP_LOW, 8'h00);
      wr(OFF_COUNT_LOW, 8'h00);
      wr(OFF_COUNT_LOW, 8'h42);
      rd(OFF_COUNT_LOW, 8'h42);
      wr(OFF_CCP_MODE, 8'h00);
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_IRQ_CLEAR, 8'h04);
      rd(OFF_IRQ_STATUS, 8'h00);
      // Asleep: internal clock stops, oscillator keeps running
      @(posedge clk) sleep <= 1'b1;
      wr(OFF_COUNT_LOW, 8'h00);
      wr(OFF_CONTROL, 8'h09);
      repeat (10) @(posedge clk);
      rd(OFF_COUNT_LOW, 8'h00);
      `CHK(osc_out, 1'b1)
      // Asynchronous external clock on the selected pin wakes the device
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_COUNT_HIGH, 8'hff);
      wr(OFF_COUNT_LOW, 8'hfe);
      wr(OFF_IRQ_CLEAR, 8'h07);
      wr(OFF_IRQ_ENABLE, 8'h01);
      wr(OFF_IRQ_CTRL, 8'h01);
      wr(OFF_CONTROL, 8'h0f);
      far.pulse(3, 3);
      rd(OFF_COUNT_LOW, 8'hfe);
      far.pulse(2, 3);
      `CHK(wake_out, 1'b1)
      `CHK(irq_out, 1'b0)
      rd(OFF_COUNT_HIGH, 8'h00);
      wr(OFF_IRQ_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      `CHK(wake_out, 1'b0)
      @(posedge clk) sleep <= 1'b0;
      print_verdict();
   end
endmodule : tmr16_timer_tb
